// ---- src/ptc_pkg.sv ----
// Constants shared by the port priority and tag control bank
package ptc_pkg;
    localparam int          PORT_COUNT     = 4;
    localparam int          VID_W          = 12;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    // Register offsets
    localparam logic [7:0]  OFF_PORT1_CTRL = 8'h10;
    localparam logic [7:0]  OFF_PORT2_CTRL = 8'h20;
    localparam logic [7:0]  OFF_PORT3_CTRL = 8'h30;
    localparam logic [7:0]  OFF_RSVD_CTRL  = 8'h40;
    localparam logic [7:0]  OFF_PORT4_CTRL = 8'h50;
    // Field positions
    localparam int          BIT_STORM      = 7;
    localparam int          BIT_DSCP_EN    = 6;
    localparam int          BIT_DOT1P_EN   = 5;
    localparam int          BIT_DEFPRI_HI  = 4;
    localparam int          BIT_DEFPRI_LO  = 3;
    localparam int          BIT_TAG_INS    = 2;
    localparam int          BIT_TAG_DEL    = 1;
    localparam int          BIT_Q_SPLIT    = 0;
    // Value after reset and queue mode codes
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [1:0]  QMODE_SINGLE   = 2'h0;
    localparam logic [1:0]  QMODE_RSVD     = 2'h3;
endpackage

// ---- src/ptc_policy_if.sv ----
// Control bytes and per-packet decisions passed between bank and policy logic
`timescale 1ns/100ps
interface ptc_policy_if;
    logic [7:0] ingCtrl;
    logic [7:0] egrCtrl;
    logic       dscpHit;
    logic [1:0] dscpPri;
    logic       tagHit;
    logic [1:0] tagPri;
    logic       rxTagged;
    logic [1:0] queue;
    logic       insertTag;
    logic       stripTag;

    modport bank   (output ingCtrl, egrCtrl, dscpHit, dscpPri, tagHit, tagPri, rxTagged,
                    input  queue, insertTag, stripTag);
    modport policy (input  ingCtrl, egrCtrl, dscpHit, dscpPri, tagHit, tagPri, rxTagged,
                    output queue, insertTag, stripTag);
endinterface

// ---- src/ptc_port_policy.sv ----
// Per-packet priority resolution from the ingress control byte and egress tag decision from the egress control byte
`timescale 1ns/100ps
module ptc_port_policy (
    ptc_policy_if.policy pif
);
    logic       dscpUse;
    logic       dot1pUse;
    logic [1:0] classPri;

    // A classifier counts only when enabled and it found a priority
    assign dscpUse  = pif.ingCtrl[ptc_pkg::BIT_DSCP_EN] & pif.dscpHit;    // see R02
    assign dot1pUse = pif.ingCtrl[ptc_pkg::BIT_DOT1P_EN] & pif.tagHit;    // see R03
    // Both classifiers may be on at once; their results are ORed
    assign classPri = (dscpUse ? pif.dscpPri : 2'h0) | (dot1pUse ? pif.tagPri : 2'h0); // see R05
    // Port default is the fallback when no classifier produced a result
    assign pif.queue = (dscpUse | dot1pUse) ? classPri
                     : pif.ingCtrl[ptc_pkg::BIT_DEFPRI_HI:ptc_pkg::BIT_DEFPRI_LO];   // see R04

    // Insert only on untagged frames, so a tagged frame never gets a second tag
    assign pif.insertTag = pif.egrCtrl[ptc_pkg::BIT_TAG_INS] & ~pif.rxTagged;    // see R06 see R07
    // Strip only on tagged frames; untagged frames are never stripped
    assign pif.stripTag  = pif.egrCtrl[ptc_pkg::BIT_TAG_DEL] & pif.rxTagged;     // see R08 see R09
endmodule

// ---- src/ptc_port_ctrl_bank.sv ----
// Per-port ingress priority and egress tag control register bank
//
// Summary of operation
// R01 - Bit 7 set enables broadcast storm protection for that port's ingress.
// R02 - Bit 6 set classifies ingress priority from the DiffServ code point.
// R03 - Bit 5 set classifies ingress priority from the 802.1p tag priority.
// R04 - Bits 4..3 give the fallback queue 0..3 when classification is off or fails.
// R05 - All three may be on; ORed 802.1p and DSCP result beats port default.
// R06 - Bit 2 set adds a tag carrying the ingress port's VLAN ID to untagged frames.
// R07 - With insertion on, frames tagged on reception are left unchanged.
// R08 - Bit 1 set strips the tag from frames tagged on reception.
// R09 - With removal on, frames received untagged pass unmodified.
// R10 - Four identical 8-bit read-write registers at 0x10/0x20/0x30/0x50, reset zero.
// R11 - Bit 0 with an external bit selects one, two or four queues; 11 reserved.
// R12 - The reserved slot at 0x40 ignores writes and reads as zero.
`timescale 1ns/100ps
module ptc_port_ctrl_bank #(
    parameter int VID_W = ptc_pkg::VID_W
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic [ptc_pkg::ADDR_W-1:0]             regAddr,
    input  wire logic                                   regWrEn,
    input  wire logic [ptc_pkg::DATA_W-1:0]             regWrData,
    input  wire logic                                   regRdEn,
    output logic      [ptc_pkg::DATA_W-1:0]             regRdData,
    output logic                                        regRdValid,
    input  wire logic [ptc_pkg::PORT_COUNT*VID_W-1:0]   portDefaultVlanId,
    input  wire logic [ptc_pkg::PORT_COUNT-1:0]         queueSplitHi,
    output logic      [ptc_pkg::PORT_COUNT-1:0]         stormProtectEn,
    output logic      [2*ptc_pkg::PORT_COUNT-1:0]       queueMode,
    input  wire logic                                   classReq,
    input  wire logic [1:0]                             classPort,
    input  wire logic                                   dscpHit,
    input  wire logic [1:0]                             dscpPri,
    input  wire logic                                   tagHit,
    input  wire logic [1:0]                             tagPri,
    output logic                                        classValid,
    output logic      [1:0]                             classQueue,
    output logic                                        classStormProtect,
    input  wire logic                                   egrReq,
    input  wire logic [1:0]                             egrPort,
    input  wire logic [1:0]                             egrSrcPort,
    input  wire logic                                   egrRxTagged,
    output logic                                        egrValid,
    output logic                                        egrInsertTag,
    output logic                                        egrStripTag,
    output logic      [VID_W-1:0]                       egrVlanId
);
    localparam int NP = ptc_pkg::PORT_COUNT;

    // Maps a register offset to {hit, port index}; the reserved slot never hits
    function automatic logic [2:0] decodeSlot(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        unique case (a)
            ptc_pkg::OFF_PORT1_CTRL: r = 3'h4;
            ptc_pkg::OFF_PORT2_CTRL: r = 3'h5;
            ptc_pkg::OFF_PORT3_CTRL: r = 3'h6;
            ptc_pkg::OFF_PORT4_CTRL: r = 3'h7;
            default:                 r = 3'h0;
        endcase
        return r;
    endfunction

    logic [7:0]       ctrl_reg [NP];
    logic [2:0]       slot;
    logic             slotHit;
    logic [1:0]       slotIdx;
    logic [7:0]       rdData_next;
    logic [VID_W-1:0] srcVid;

    ptc_policy_if pif ();

    // Address decode shared by reads and writes
    assign slot        = decodeSlot(regAddr);
    assign slotHit     = slot[2];
    assign slotIdx     = slot[1:0];
    // Reserved and unmapped offsets read zero
    assign rdData_next = slotHit ? ctrl_reg[slotIdx] : 8'h00;    // see R12

    // Control storage; every field is read-write including the split bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NP; i++)
                ctrl_reg[i] <= ptc_pkg::CTRL_RESET;              // see R10
        end
        else if (regWrEn && slotHit)
        begin
            ctrl_reg[slotIdx] <= regWrData;                      // see R10 see R12
        end
    end

    // Read data is registered and answers one cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (regRdEn)
                regRdData <= rdData_next;
        end
    end

    // Static per-port levels; a reserved split code falls back to one queue
    // so the queue manager never sees an undefined mode
    genvar g;
    generate
        for (g = 0; g < NP; g++)
        begin : gPort
            logic [1:0] rawMode;
            assign rawMode = {queueSplitHi[g], ctrl_reg[g][ptc_pkg::BIT_Q_SPLIT]};
            assign queueMode[2*g+1:2*g] = (rawMode == ptc_pkg::QMODE_RSVD) ?
                                          ptc_pkg::QMODE_SINGLE : rawMode;       // see R11
            assign stormProtectEn[g]    = ctrl_reg[g][ptc_pkg::BIT_STORM];       // see R01
        end
    endgenerate

    // Ingress side uses the arrival port, egress side the output port
    assign pif.ingCtrl  = ctrl_reg[classPort];
    assign pif.egrCtrl  = ctrl_reg[egrPort];
    assign pif.dscpHit  = dscpHit;
    assign pif.dscpPri  = dscpPri;
    assign pif.tagHit   = tagHit;
    assign pif.tagPri   = tagPri;
    assign pif.rxTagged = egrRxTagged;
    // Inserted tag carries the VLAN ID of the port the frame came in on
    assign srcVid       = portDefaultVlanId[egrSrcPort*VID_W +: VID_W];   // see R06

    ptc_port_policy uPolicy (
        .pif (pif.policy)
    );

    // Ingress decision registered one cycle after the request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            classValid        <= 1'b0;
            classQueue        <= 2'h0;
            classStormProtect <= 1'b0;
        end
        else
        begin
            classValid <= classReq;
            if (classReq)
            begin
                classQueue        <= pif.queue;                              // see R05
                classStormProtect <= pif.ingCtrl[ptc_pkg::BIT_STORM];        // see R01
            end
        end
    end

    // Egress decision registered one cycle after the request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            egrValid     <= 1'b0;
            egrInsertTag <= 1'b0;
            egrStripTag  <= 1'b0;
            egrVlanId    <= '0;
        end
        else
        begin
            egrValid <= egrReq;
            if (egrReq)
            begin
                egrInsertTag <= pif.insertTag;                               // see R06
                egrStripTag  <= pif.stripTag;                                // see R08
                egrVlanId    <= srcVid;
            end
        end
    end

    // Checks kept beside the logic
    property p_storm;    // see R01
        @(posedge clk) disable iff (rst)
        (regWrEn && regAddr == ptc_pkg::OFF_PORT1_CTRL) |=> stormProtectEn[0] == $past(regWrData[7]);
    endproperty
    a_storm: assert property (p_storm) else $error("storm enable does not follow write");

    property p_dscp;    // see R02
        @(posedge clk) disable iff (rst)
        (classReq && pif.ingCtrl[6] && dscpHit && !(pif.ingCtrl[5] && tagHit)) |=>
            classValid && classQueue == $past(dscpPri);
    endproperty
    a_dscp: assert property (p_dscp) else $error("DiffServ priority not applied");

    property p_dot1p;    // see R03
        @(posedge clk) disable iff (rst)
        (classReq && pif.ingCtrl[5] && tagHit && !(pif.ingCtrl[6] && dscpHit)) |=>
            classQueue == $past(tagPri);
    endproperty
    a_dot1p: assert property (p_dot1p) else $error("802.1p priority not applied");

    property p_default;    // see R04
        @(posedge clk) disable iff (rst)
        (classReq && !(pif.ingCtrl[6] && dscpHit) && !(pif.ingCtrl[5] && tagHit)) |=>
            classQueue == $past(pif.ingCtrl[4:3]);
    endproperty
    a_default: assert property (p_default) else $error("port default priority not applied");

    property p_orMerge;    // see R05
        @(posedge clk) disable iff (rst)
        (classReq && pif.ingCtrl[6] && dscpHit && pif.ingCtrl[5] && tagHit) |=>
            classQueue == ($past(dscpPri) | $past(tagPri));
    endproperty
    a_orMerge: assert property (p_orMerge) else $error("merged priority is not the OR");

    property p_insert;    // see R06
        @(posedge clk) disable iff (rst)
        (egrReq && pif.egrCtrl[2] && !egrRxTagged) |=> egrValid && egrInsertTag && egrVlanId == $past(srcVid);
    endproperty
    a_insert: assert property (p_insert) else $error("tag not inserted with source VLAN ID");

    property p_noDouble;    // see R07
        @(posedge clk) disable iff (rst)
        (egrReq && (egrRxTagged || !pif.egrCtrl[2])) |=> !egrInsertTag;
    endproperty
    a_noDouble: assert property (p_noDouble) else $error("tag inserted where not allowed");

    property p_strip;    // see R08
        @(posedge clk) disable iff (rst)
        (egrReq && egrRxTagged) |=> egrStripTag == $past(pif.egrCtrl[1]);
    endproperty
    a_strip: assert property (p_strip) else $error("tag removal does not follow control bit");

    property p_untaggedPass;    // see R09
        @(posedge clk) disable iff (rst)
        (egrReq && !egrRxTagged) |=> !egrStripTag;
    endproperty
    a_untaggedPass: assert property (p_untaggedPass) else $error("untagged frame marked for strip");

    property p_rsvdRead;    // see R12
        @(posedge clk) disable iff (rst)
        (regRdEn && regAddr == ptc_pkg::OFF_RSVD_CTRL) |=> regRdValid && regRdData == 8'h00;
    endproperty
    a_rsvdRead: assert property (p_rsvdRead) else $error("reserved slot did not read zero");

    property p_readBack;    // see R10
        @(posedge clk) disable iff (rst)
        (regWrEn && regAddr == ptc_pkg::OFF_PORT4_CTRL) ##1
            (regRdEn && !regWrEn && regAddr == ptc_pkg::OFF_PORT4_CTRL) |=> regRdData == $past(regWrData, 2);
    endproperty
    a_readBack: assert property (p_readBack) else $error("port register read-back mismatch");

    property p_qmode;    // see R11
        @(posedge clk) disable iff (rst)
        queueMode[1:0] == (({queueSplitHi[0], ctrl_reg[0][0]} == 2'h3) ? 2'h0 : {queueSplitHi[0], ctrl_reg[0][0]});
    endproperty
    a_qmode: assert property (p_qmode) else $error("queue mode mismatch");
endmodule

// ---- tb/port_priority_tag_control_bench.sv ----
// Self-checking bench for the port priority and tag control register bank
`timescale 1ns/100ps
module port_priority_tag_control_bench;
    logic        clk, rst, regWrEn, regRdEn, regRdValid;
    logic [7:0]  regAddr, regWrData, regRdData, queueMode;
    logic [47:0] portDefaultVlanId;
    logic [3:0]  queueSplitHi, stormProtectEn;
    logic        classReq, dscpHit, tagHit, classValid, classStormProtect;
    logic [1:0]  classPort, dscpPri, tagPri, classQueue, egrPort, egrSrcPort;
    logic        egrReq, egrRxTagged, egrValid, egrInsertTag, egrStripTag;
    logic [11:0] egrVlanId;
    int          n_errors, tests_run;
    int          regModel [4];
    int          eQ, eS, eIns, eDel, eVid;
    logic [7:0]  offs [6];

    ptc_port_ctrl_bank ptc_port_ctrl_bank_inst (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .portDefaultVlanId(portDefaultVlanId), .queueSplitHi(queueSplitHi),
        .stormProtectEn(stormProtectEn), .queueMode(queueMode), .classReq(classReq),
        .classPort(classPort), .dscpHit(dscpHit), .dscpPri(dscpPri), .tagHit(tagHit),
        .tagPri(tagPri), .classValid(classValid), .classQueue(classQueue),
        .classStormProtect(classStormProtect), .egrReq(egrReq), .egrPort(egrPort),
        .egrSrcPort(egrSrcPort), .egrRxTagged(egrRxTagged), .egrValid(egrValid),
        .egrInsertTag(egrInsertTag), .egrStripTag(egrStripTag), .egrVlanId(egrVlanId)
    );

    // 250 MHz clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Map an offset to a port slot; anything else is not backed by storage
    function automatic int slot(input logic [7:0] a);
        for (int k = 0; k < 4; k++)
            if (a === offs[k])
                return k;
        return -1;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int s;
        s = slot(a);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        if (s >= 0)
            regModel[s] = d;
    endtask

    task automatic rd(input logic [7:0] a);
        int s;
        s = slot(a);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check("regRdValid", regRdValid, 1);
        check("regRdData", regRdData, (s < 0) ? 0 : regModel[s]);
    endtask

    // Random back-to-back requests; the last cycle issues none so held outputs stay modelled
    task automatic traffic(input int n);
        int p, d, t, q, cv, ev;
        logic [31:0] r;
        logic [63:0] w;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            cv = classReq;
            ev = egrReq;
            if (classReq)
            begin
                p = regModel[classPort];
                d = p[6] & dscpHit;
                t = p[5] & tagHit;
                eQ = (d | t) ? ((d ? dscpPri : 0) | (t ? tagPri : 0)) : p[4:3];
                eS = p[7];
            end
            if (egrReq)
            begin
                p = regModel[egrPort];
                eIns = p[2] & !egrRxTagged;
                eDel = p[1] & egrRxTagged;
                eVid = portDefaultVlanId[egrSrcPort*12 +: 12];
            end
            r = $urandom;
            w = {$urandom, $urandom};
            classReq <= r[0] & (i < n - 1);
            {classPort, dscpHit, dscpPri, tagHit, tagPri} <= r[8:1];
            egrReq <= r[9] & (i < n - 1);
            {egrPort, egrSrcPort, egrRxTagged} <= r[14:10];
            queueSplitHi <= r[18:15];
            portDefaultVlanId <= w[47:0];
            #1;
            check("classValid", classValid, cv);
            check("classQueue", classQueue, eQ);
            check("classStormProtect", classStormProtect, eS);
            check("egrValid", egrValid, ev);
            check("egrInsertTag", egrInsertTag, eIns);
            check("egrStripTag", egrStripTag, eDel);
            check("egrVlanId", egrVlanId, eVid);
            for (int k = 0; k < 4; k++)
            begin
                q = {queueSplitHi[k], regModel[k][0]};
                check("stormProtectEn", stormProtectEn[k], regModel[k][7]);
                check("queueMode", queueMode[2*k +: 2], (q == 3) ? 0 : q);
            end
        end
    endtask

    // Hang guard, far above the roughly 1850 cycles the sequence needs
    initial
    begin
        #(4 * 20000);
        n_errors++;
        conclude();
    end

    initial
    begin
        offs = '{ptc_pkg::OFF_PORT1_CTRL, ptc_pkg::OFF_PORT2_CTRL, ptc_pkg::OFF_PORT3_CTRL,
                 ptc_pkg::OFF_PORT4_CTRL, ptc_pkg::OFF_RSVD_CTRL, 8'h11};
        {regWrEn, regRdEn, regAddr, regWrData, portDefaultVlanId, queueSplitHi} = '0;
        {classReq, classPort, dscpHit, dscpPri, tagHit, tagPri} = '0;
        {egrReq, egrPort, egrSrcPort, egrRxTagged} = '0;
        n_errors = 0;
        tests_run = 0;
        void'($urandom(32'h6F58B6D3));
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values, reserved and unmapped slots
        foreach (offs[k]) rd(offs[k]);
        traffic(2);
        // Random control bytes per round, with writes to places that must ignore them
        for (int round = 0; round < 8; round++)
        begin
            for (int k = 0; k < 4; k++)
                wr(offs[k], 8'($urandom));
            wr(ptc_pkg::OFF_RSVD_CTRL, 8'hFF);
            wr(8'($urandom), 8'($urandom));
            traffic(200);
            foreach (offs[k]) rd(offs[k]);
        end
        // Write and read in one cycle returns the previous contents
        @(posedge clk);
        regAddr <= ptc_pkg::OFF_PORT2_CTRL;
        regWrData <= 8'hA5;
        regWrEn <= 1'b1;
        regRdEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        #1;
        check("regRdData", regRdData, regModel[1]);
        regModel[1] = 8'hA5;
        rd(ptc_pkg::OFF_PORT2_CTRL);
        // Write then read on the very next cycle, so the new byte must already be stored
        regModel[3] = $urandom & 8'hFF;
        @(posedge clk);
        regAddr <= ptc_pkg::OFF_PORT4_CTRL;
        regWrData <= 8'(regModel[3]);
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check("regRdValid", regRdValid, 1);
        check("regRdData", regRdData, regModel[3]);
        // Second reset in mid-run clears every register and held output
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        regModel = '{0, 0, 0, 0};
        {eQ, eS, eIns, eDel, eVid} = '0;
        traffic(3);
        foreach (offs[k]) rd(offs[k]);
        conclude();
    end
endmodule
